//--- dv/ciwm_src_core_model.sv
// peripheral sources and core model facing the interrupt block
// assumes bench raise pulses, one clock shared with the block
module ciwm_src_core_model
  import ciwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [20:0] raise,
  input wire logic [7:0] hold_cyc,
  input wire logic vec_valid,
  input wire logic [5:0] vec_id,
  output logic [20:0] lines,
  output logic exc_return
);
  timeunit 1ns;
  timeprecision 1ps;
  // handler stack: a preempted handler pauses until the inner one returns
  int rem[$];
  initial
  begin
    lines = '0;
    exc_return = 1'b0;
  end
  always @(posedge clk)
  begin
    exc_return <= 1'b0;
    if (!rst_b)
    begin
      lines <= '0;
      rem.delete();
    end
    else
    begin
      lines <= lines | raise;
      // software clears the cause as the handler starts
      if (vec_valid && vec_id >= 6'h10)
        lines[vec_id - 6'h10] <= 1'b0;
      if (vec_valid)
        rem.push_front(int'(hold_cyc));
      else if (rem.size() > 0)
      begin
        if (rem[0] == 0)
        begin
          exc_return <= 1'b1;
          void'(rem.pop_front());
        end
        else
          rem[0]--;
      end
    end
  end
endmodule : ciwm_src_core_model

//--- dv/tb_cpu_interrupt_wakeup_map.sv
// bench for the interrupt routing, tick timer and sleep wake block
// assumes the source and core model answers every delivered vector
module tb_cpu_interrupt_wakeup_map
  import ciwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WRC = 2;
  typedef struct packed {logic [4:0] line; logic [5:0] vec;} ciwm_row_s;
  ciwm_row_s rows [21];
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [20:0] raise = '0;
  logic [7:0] hold_cyc = 8'h04;
  logic [20:0] lines;
  logic exc_return;
  logic [20:0] irq_enable = '1;
  logic [20:0][7:0] irq_priority = '0;
  logic [7:0] tick_priority = 8'h00;
  logic tick_enable = 1'b0;
  logic tick_clock_select = 1'b0;
  logic [23:0] tick_reload = 24'h000005;
  logic deep_sleep_bit = 1'b0;
  logic core_sleep_req = 1'b0;
  logic watchdog_irq = 1'b0;
  logic vec_valid, tick_wrap, core_powered_down, core_wake;
  logic [5:0] vec_id;
  logic [23:0] tick_count, t0;
  int pick = 0;
  int n_mismatch = 0;
  int n_checks = 0;
  int lat, g;
  always #5 clk = ~clk;
  ciwm_src_core_model ciwm_src_core_model_i (.clk(clk), .rst_b(rst_b), .raise(raise), .hold_cyc(hold_cyc),
    .vec_valid(vec_valid), .vec_id(vec_id), .lines(lines), .exc_return(exc_return));
  ciwm_core #(.WAKE_RESTORE_CYC(WRC)) ciwm_core_i (.clk(clk), .rst_b(rst_b),
    .radio_sleep_wake_irq(lines[0]), .link_src(ciwm_link_src_s'(9'(lines[1]) << (pick % 9))),
    .serial_port_a_irq(lines[2]), .serial_port_b_irq(lines[3]), .two_wire_irq(lines[4]),
    .sync_serial_irq(lines[5]), .converter_irq(lines[6]), .key_scanner_irq(lines[7]),
    .radio_diag_events(8'(lines[8]) << (pick % 8)), .radio_diag_select(3'(pick % 8)),
    .radio_calibration_irq(lines[9]), .pin_event_irq(lines[14:10]), .shared_timer_irq(lines[15]),
    .wake_capture_timer_irq(lines[16] && pick % 3 == 0), .pin_group_irq(lines[16] && pick % 3 == 1),
    .decoder_irq(lines[16] && pick % 3 == 2), .wide_timer_irq(lines[17]), .calendar_clock_irq(lines[18]),
    .transfer_engine_irq(lines[19]), .crystal_settled_irq(lines[20]), .watchdog_irq(watchdog_irq),
    .irq_enable(irq_enable), .irq_priority(irq_priority), .tick_priority(tick_priority),
    .tick_enable(tick_enable), .tick_clock_select(tick_clock_select), .tick_reload(tick_reload),
    .deep_sleep_bit(deep_sleep_bit), .core_sleep_req(core_sleep_req), .exc_return(exc_return),
    .vec_valid(vec_valid), .vec_id(vec_id), .tick_count(tick_count), .tick_wrap(tick_wrap),
    .core_powered_down(core_powered_down), .core_wake(core_wake));
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic fire(input logic [20:0] m);
    @(posedge clk);
    raise <= m;
    @(posedge clk);
    raise <= '0;
  endtask : fire
  // bounded wait for the next delivery, counting cycles
  task automatic wait_vec(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (vec_valid !== 1'b1 && n < 80);
  endtask : wait_vec
  task automatic expect_vec(input logic [5:0] exp);
    wait_vec(lat);
    check("vec_id", vec_id, exp);
  endtask : expect_vec
  task automatic wrap_gap(output int n);
    n = 0;
    while (tick_wrap !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tick_wrap !== 1'b1 && n < 1000);
  endtask : wrap_gap
  initial
  begin
    #500000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    for (int i = 0; i < 21; i++)
      rows[i] = '{5'(i), 6'(6'h10 + i)};
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    check("tick_count_rst", tick_count, 24'h000000);
    // every source path, rotating the sub-source picks between passes
    for (int p = 0; p < 9; p++)
      for (int r = 0; r < 21; r++)
      begin
        @(posedge clk);
        pick <= p;
        fire(21'(1) << rows[r].line);
        expect_vec(rows[r].vec);
        check("latency", 24'(lat), 24'h000012);
        repeat (12) @(posedge clk);
      end
    fire(21'h000028);
    expect_vec(6'h13);
    expect_vec(6'h15);
    @(posedge clk);
    irq_priority[3] <= 8'hC0;
    irq_priority[9] <= 8'h40;
    fire(21'h000208);
    expect_vec(6'h19);
    expect_vec(6'h13);
    @(posedge clk);
    hold_cyc <= 8'hC8;
    fire(21'h000008);
    expect_vec(6'h13);
    fire(21'h001000);
    expect_vec(6'h1C);
    @(posedge clk);
    hold_cyc <= 8'h04;
    repeat (450) @(posedge clk);
    irq_enable[7] <= 1'b0;
    fire(21'h000080);
    wait_vec(lat);
    check("masked", vec_valid, 24'h000000);
    @(posedge clk);
    irq_enable[7] <= 1'b1;
    expect_vec(6'h17);
    repeat (12) @(posedge clk);
    watchdog_irq <= 1'b1;
    expect_vec(6'h02);
    @(posedge clk);
    watchdog_irq <= 1'b0;
    repeat (12) @(posedge clk);
    tick_clock_select <= 1'b1;
    tick_enable <= 1'b1;
    expect_vec(6'h0F);
    wrap_gap(g);
    check("tick_gap_core", g, 24'h000006);
    @(posedge clk);
    tick_clock_select <= 1'b0;
    wrap_gap(g);
    wrap_gap(g);
    check("tick_gap_ref", g, 24'h000258);
    @(posedge clk);
    tick_enable <= 1'b0;
    repeat (60) @(posedge clk);
    core_sleep_req <= 1'b1;
    repeat (6) @(negedge clk);
    check("no_sleep", core_powered_down, 24'h000000);
    @(posedge clk);
    tick_reload <= 24'h0003FF;
    tick_clock_select <= 1'b1;
    tick_enable <= 1'b1;
    core_sleep_req <= 1'b0;
    repeat (60) @(posedge clk);
    deep_sleep_bit <= 1'b1;
    core_sleep_req <= 1'b1;
    for (int i = 0; i < 40 && core_powered_down !== 1'b1; i++)
      @(negedge clk);
    check("asleep", core_powered_down, 24'h000001);
    @(posedge clk);
    core_sleep_req <= 1'b0;
    t0 = tick_count;
    repeat (20) @(negedge clk);
    check("tick_stopped", tick_count, t0);
    @(posedge clk);
    tick_enable <= 1'b0;
    fire(21'h000001);
    for (g = 0; g < 40 && core_wake !== 1'b1; g++)
      @(negedge clk);
    check("wake_lat", 24'(g >= WRC && g <= WRC + 4), 24'h000001);
    expect_vec(6'h10);
    check("awake", core_powered_down, 24'h000000);
    repeat (12) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_cpu_interrupt_wakeup_map

//--- src/ciwm_core.sv
// interrupt mapping, priority arbitration, nesting, tick timer and sleep wake detector
// assumes synchronous inputs, level requests held by sources, one exc_return pulse per handler end
`include "ciwm_map.svh"
module ciwm_core
  import ciwm_pkg::*;
#(
  parameter int unsigned WAKE_RESTORE_CYC = `CIWM_WAKE_RESTORE_CYC
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic radio_sleep_wake_irq,
  input wire ciwm_link_src_s link_src,
  input wire logic serial_port_a_irq,
  input wire logic serial_port_b_irq,
  input wire logic two_wire_irq,
  input wire logic sync_serial_irq,
  input wire logic converter_irq,
  input wire logic key_scanner_irq,
  input wire logic [`CIWM_DIAG_W-1:0] radio_diag_events,
  input wire logic [`CIWM_DIAG_SEL_W-1:0] radio_diag_select,
  input wire logic radio_calibration_irq,
  input wire logic [4:0] pin_event_irq,
  input wire logic shared_timer_irq,
  input wire logic wake_capture_timer_irq,
  input wire logic pin_group_irq,
  input wire logic decoder_irq,
  input wire logic wide_timer_irq,
  input wire logic calendar_clock_irq,
  input wire logic transfer_engine_irq,
  input wire logic crystal_settled_irq,
  input wire logic watchdog_irq,
  input wire logic [`CIWM_NUM_IRQ-1:0] irq_enable,
  input wire logic [`CIWM_NUM_IRQ-1:0][7:0] irq_priority,
  input wire logic [7:0] tick_priority,
  input wire logic tick_enable,
  input wire logic tick_clock_select,
  input wire logic [`CIWM_TICK_W-1:0] tick_reload,
  input wire logic deep_sleep_bit,
  input wire logic core_sleep_req,
  input wire logic exc_return,
  output logic vec_valid,
  output logic [5:0] vec_id,
  output logic [`CIWM_TICK_W-1:0] tick_count,
  output logic tick_wrap,
  output logic core_powered_down,
  output logic core_wake
);
  ciwm_state_s s_ff;
  ciwm_state_s nxt_s;
  logic [`CIWM_NUM_IRQ-1:0] raw;
  logic wake_capture_decoder_irq;
  logic radio_general_irq;
  logic radio_diag_irq;
  logic best_ok;
  logic best_is_irq;
  logic [4:0] best_idx;
  logic [1:0] best_lvl;
  logic [2:0] cur_lvl;
  logic arb_bad;
  logic start_irq;
  logic wd_rise;

  // fixed source-to-line map; the wake detector sees these enabled wires plus the watchdog rise and a pending nmi
  assign radio_general_irq = |link_src;
  assign radio_diag_irq = radio_diag_events[radio_diag_select];
  assign wake_capture_decoder_irq = wake_capture_timer_irq | pin_group_irq | decoder_irq;
  assign raw = {crystal_settled_irq, transfer_engine_irq, calendar_clock_irq,
                wide_timer_irq, wake_capture_decoder_irq, shared_timer_irq,
                pin_event_irq,
                radio_calibration_irq, radio_diag_irq,
                key_scanner_irq, converter_irq, sync_serial_irq, two_wire_irq,
                serial_port_b_irq, serial_port_a_irq,
                radio_general_irq, radio_sleep_wake_irq};
  assign wd_rise = watchdog_irq & ~s_ff.wd_prev;

  // ascending scan with strict compare keeps the lowest number on ties
  always_comb
  begin
    best_ok = s_ff.tick_pend & tick_enable;
    best_is_irq = 1'b0;
    best_idx = 5'h00;
    best_lvl = best_ok ? tick_priority[`CIWM_PRIO_LVL_MSB:`CIWM_PRIO_LVL_LSB] : 2'h3;
    for (int i = 0; i < `CIWM_NUM_IRQ; i++)
    begin
      if (s_ff.pend[i] && irq_enable[i]
          && (!best_ok || irq_priority[i][`CIWM_PRIO_LVL_MSB:`CIWM_PRIO_LVL_LSB] < best_lvl))
      begin
        best_ok = 1'b1;
        best_is_irq = 1'b1;
        best_idx = 5'(i);
        best_lvl = irq_priority[i][`CIWM_PRIO_LVL_MSB:`CIWM_PRIO_LVL_LSB];
      end
    end
    cur_lvl = `CIWM_LVL_NONE;
    for (int l = `CIWM_NUM_LVL - 1; l >= 0; l--)
    begin
      if (s_ff.act[l])
      begin
        cur_lvl = 3'(l);
      end
    end
  end

  assign start_irq = s_ff.st == CIWM_IDLE && !(s_ff.nmi_pend && !s_ff.nmi_act)
                     && !s_ff.nmi_act && best_ok && {1'b0, best_lvl} < cur_lvl;

  always_comb
  begin
    logic take;
    logic tick_step;
    logic tick_fire;
    nxt_s = s_ff;
    take = s_ff.st == CIWM_WAIT && s_ff.cnt == 8'h00;
    tick_step = 1'b0;
    tick_fire = 1'b0;
    nxt_s.vec_valid = 1'b0;
    nxt_s.wake = 1'b0;
    nxt_s.tick_wrap = 1'b0;
    nxt_s.ref_en = 1'b0;
    nxt_s.wd_prev = watchdog_irq;
    if (s_ff.ref_cnt == 7'(`CIWM_REF_DIV - 1))
    begin
      nxt_s.ref_cnt = 7'h00;
      nxt_s.ref_en = 1'b1;
    end
    else
    begin
      nxt_s.ref_cnt = s_ff.ref_cnt + 7'h01;
    end
    if (tick_enable && !s_ff.down)
    begin
      tick_step = (tick_clock_select == `CIWM_TICK_SEL_CORE) ? 1'b1 : s_ff.ref_en;
    end
    if (tick_step)
    begin
      if (s_ff.tick_cnt == '0)
      begin
        nxt_s.tick_cnt = tick_reload;
        nxt_s.tick_wrap = 1'b1;
        tick_fire = 1'b1;
      end
      else
      begin
        nxt_s.tick_cnt = s_ff.tick_cnt - `CIWM_TICK_W'(1);
      end
    end
    // a level still high at the take and vector edges is the request just taken, not a new one
    for (int i = 0; i < `CIWM_NUM_IRQ; i++)
    begin
      nxt_s.pend[i] = (raw[i] | s_ff.pend[i]) & ~(take && s_ff.cap_is_irq && s_ff.cap_irq == 5'(i))
                      & ~(s_ff.vec_valid && s_ff.vec_id == 6'(`CIWM_VEC_IRQ_BASE + i));
    end
    nxt_s.tick_pend = tick_fire | (s_ff.tick_pend & ~(take && s_ff.cap_vec == `CIWM_VEC_TICK));
    nxt_s.nmi_pend = wd_rise | (s_ff.nmi_pend & ~(take && s_ff.cap_vec == `CIWM_VEC_NMI));
    if (exc_return)
    begin
      if (s_ff.nmi_act)
      begin
        nxt_s.nmi_act = 1'b0;
      end
      else if (cur_lvl != `CIWM_LVL_NONE)
      begin
        nxt_s.act[cur_lvl[1:0]] = 1'b0;
      end
    end
    unique case (s_ff.st)
      CIWM_IDLE:
      begin
        if (s_ff.nmi_pend && !s_ff.nmi_act)
        begin
          nxt_s.st = CIWM_WAIT;
          nxt_s.cnt = 8'(`CIWM_LAT_CYC - 1);
          nxt_s.cap_vec = `CIWM_VEC_NMI;
          nxt_s.cap_is_irq = 1'b0;
        end
        else if (start_irq)
        begin
          nxt_s.st = CIWM_WAIT;
          nxt_s.cnt = 8'(`CIWM_LAT_CYC - 1);
          nxt_s.cap_vec = best_is_irq ? `CIWM_VEC_IRQ_BASE + {1'b0, best_idx} : `CIWM_VEC_TICK;
          nxt_s.cap_is_irq = best_is_irq;
          nxt_s.cap_irq = best_idx;
          nxt_s.cap_lvl = best_lvl;
        end
        else if (core_sleep_req && deep_sleep_bit)
        begin
          nxt_s.st = CIWM_SLEEP;
          nxt_s.down = 1'b1;
        end
      end
      CIWM_WAIT:
      begin
        // captured choice is held through the latency; a later winner waits its turn
        if (take)
        begin
          nxt_s.st = CIWM_IDLE;
          nxt_s.vec_valid = 1'b1;
          nxt_s.vec_id = s_ff.cap_vec;
          if (s_ff.cap_vec == `CIWM_VEC_NMI)
          begin
            nxt_s.nmi_act = 1'b1;
          end
          else
          begin
            nxt_s.act[s_ff.cap_lvl] = 1'b1;
          end
        end
        else
        begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      CIWM_SLEEP:
      begin
        // pure wire detect, no setup state of its own
        if (|(raw & irq_enable) || wd_rise || s_ff.nmi_pend)
        begin
          nxt_s.st = CIWM_RESTORE;
          nxt_s.cnt = 8'(WAKE_RESTORE_CYC - 1);
        end
      end
      CIWM_RESTORE:
      begin
        if (s_ff.cnt == 8'h00)
        begin
          nxt_s.st = CIWM_IDLE;
          nxt_s.down = 1'b0;
          nxt_s.wake = 1'b1;
        end
        else
        begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      default:
      begin
        nxt_s.st = CIWM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign vec_valid = s_ff.vec_valid;
  assign vec_id = s_ff.vec_id;
  assign tick_count = s_ff.tick_cnt;
  assign tick_wrap = s_ff.tick_wrap;
  assign core_powered_down = s_ff.down;
  assign core_wake = s_ff.wake;

  // independent check of the chosen line against all other enabled pending lines
  always_comb
  begin
    arb_bad = 1'b0;
    for (int j = 0; j < `CIWM_NUM_IRQ; j++)
    begin
      if (s_ff.pend[j] && irq_enable[j]
          && (irq_priority[j][7:6] < best_lvl || (irq_priority[j][7:6] == best_lvl && 5'(j) < best_idx)))
      begin
        arb_bad = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_enter_wait;
    s_ff.st == CIWM_IDLE ##1 s_ff.st == CIWM_WAIT;
  endsequence
  sequence s_enter_restore;
    s_ff.st == CIWM_SLEEP ##1 s_ff.st == CIWM_RESTORE;
  endsequence

  property p_latency;
    s_enter_wait |-> !vec_valid [*8] ##8 vec_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("vector not at fixed latency");

  property p_arb_order;
    start_irq && best_is_irq |-> !arb_bad;
  endproperty
  a_arb_order: assert property (p_arb_order) else $error("arbitration picked wrong line");

  property p_nest_level;
    vec_valid && vec_id >= `CIWM_VEC_TICK |-> s_ff.act[$past(s_ff.cap_lvl)];
  endproperty
  a_nest_level: assert property (p_nest_level) else $error("active level not recorded");

  property p_vector;
    start_irq && best_is_irq |=> s_ff.cap_vec == `CIWM_VEC_IRQ_BASE + {1'b0, $past(best_idx)};
  endproperty
  a_vector: assert property (p_vector) else $error("vector does not match line");

  property p_watchdog_nmi;
    s_ff.st == CIWM_IDLE && wd_rise && !s_ff.nmi_act && !start_irq
      |=> ##1 s_ff.st == CIWM_WAIT && s_ff.cap_vec == `CIWM_VEC_NMI;
  endproperty
  a_watchdog_nmi: assert property (p_watchdog_nmi) else $error("watchdog did not raise nmi");

  property p_tick_ref;
    tick_enable && tick_clock_select == `CIWM_TICK_SEL_REF && !s_ff.ref_en |=> $stable(tick_count);
  endproperty
  a_tick_ref: assert property (p_tick_ref) else $error("tick moved without reference enable");

  property p_tick_stop;
    core_powered_down |=> $stable(tick_count);
  endproperty
  a_tick_stop: assert property (p_tick_stop) else $error("tick ran while powered down");

  property p_tick_reload;
    tick_wrap |-> tick_count == $past(tick_reload) && $past(tick_count) == '0;
  endproperty
  a_tick_reload: assert property (p_tick_reload) else $error("tick reload wrong");

  property p_deep_only;
    s_ff.st == CIWM_IDLE && !deep_sleep_bit |=> s_ff.st != CIWM_SLEEP;
  endproperty
  a_deep_only: assert property (p_deep_only) else $error("slept without deep sleep bit");

  property p_restore;
    s_enter_restore |-> core_powered_down ##[1:300] (core_wake && !core_powered_down);
  endproperty
  a_restore: assert property (p_restore) else $error("wake restore not bounded");

endmodule : ciwm_core

//--- src/ciwm_map.svh
// constants for the interrupt routing, tick timer and sleep wake logic
// assumes one 100 MHz clock and a core that accepts one vector pulse at a time
`ifndef CIWM_MAP_SVH
`define CIWM_MAP_SVH
`define CIWM_NUM_IRQ 21
`define CIWM_NUM_LVL 4
`define CIWM_LVL_NONE 3'h4
`define CIWM_PRIO_LVL_MSB 7
`define CIWM_PRIO_LVL_LSB 6
`define CIWM_LAT_CYC 15
`define CIWM_CLK_HZ 100000000
`define CIWM_REF_HZ 1000000
`define CIWM_REF_DIV (`CIWM_CLK_HZ / `CIWM_REF_HZ)
`define CIWM_TICK_W 24
`define CIWM_TICK_SEL_REF 1'b0
`define CIWM_TICK_SEL_CORE 1'b1
`define CIWM_VEC_NMI 6'h02
`define CIWM_VEC_TICK 6'h0F
`define CIWM_VEC_IRQ_BASE 6'h10
`define CIWM_WAKE_RESTORE_CYC 8
`define CIWM_DIAG_W 8
`define CIWM_DIAG_SEL_W 3
`endif

//--- src/ciwm_pkg.sv
// types for the interrupt routing, tick timer and sleep wake logic
// assumes ciwm_map.svh constants
`include "ciwm_map.svh"
package ciwm_pkg;
  typedef enum logic [2:0] {
    CIWM_IDLE = 3'h0,
    CIWM_WAIT = 3'h1,
    CIWM_SLEEP = 3'h2,
    CIWM_RESTORE = 3'h6
  } ciwm_state_e;

  typedef struct packed {
    logic fine_target_timer_event;
    logic gross_target_timer_event;
    logic base_tick_event;
    logic sleep_end_event;
    logic radio_error_event;
    logic packet_received_event;
    logic radio_event_end;
    logic cipher_done_event;
    logic radio_soft_request;
  } ciwm_link_src_s;

  typedef struct packed {
    ciwm_state_e st;
    logic [7:0] cnt;
    logic [5:0] cap_vec;
    logic [4:0] cap_irq;
    logic cap_is_irq;
    logic [1:0] cap_lvl;
    logic [`CIWM_NUM_IRQ-1:0] pend;
    logic tick_pend;
    logic nmi_pend;
    logic nmi_act;
    logic [`CIWM_NUM_LVL-1:0] act;
    logic wd_prev;
    logic [6:0] ref_cnt;
    logic ref_en;
    logic [`CIWM_TICK_W-1:0] tick_cnt;
    logic tick_wrap;
    logic vec_valid;
    logic [5:0] vec_id;
    logic down;
    logic wake;
  } ciwm_state_s;
endpackage : ciwm_pkg
